// File: logic/rtc_pkg.sv
// Package with register map, field positions, reset values and timing counts of the clock core.
package rtc_pkg;

  // ********************************
  // Timing.
  // ********************************
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 32_768;
  localparam int SEC_TIME_S = 1;
  localparam int SEC_CYCLES_DFLT = SEC_TIME_S * CLK_HZ;
  localparam int PULSE_CYCLES = CLK_HZ / OSC_HZ;
  localparam int REFCLK_HALF_CYCLES = CLK_HZ / (2 * OSC_HZ);
  localparam int TEST_SPEEDUP = 64;
  localparam int CORR0_TIME_H = 2;
  localparam int CORR1_TIME_MIN = 4;
  localparam logic [12:0] CORR0_SECONDS = 13'(CORR0_TIME_H * 3600);
  localparam logic [12:0] CORR1_SECONDS = 13'(CORR1_TIME_MIN * 60);
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h51;

  // ********************************
  // Register offsets.
  // ********************************
  localparam logic [3:0] REG_CTRL1 = 4'h0;
  localparam logic [3:0] REG_CTRL2 = 4'h1;
  localparam logic [3:0] REG_OFFSET = 4'h2;
  localparam logic [3:0] REG_SCRATCH = 4'h3;
  localparam logic [3:0] REG_SEC = 4'h4;
  localparam logic [3:0] REG_MIN = 4'h5;
  localparam logic [3:0] REG_HOUR = 4'h6;
  localparam logic [3:0] REG_DAY = 4'h7;
  localparam logic [3:0] REG_WDAY = 4'h8;
  localparam logic [3:0] REG_MON = 4'h9;
  localparam logic [3:0] REG_YEAR = 4'ha;
  localparam logic [3:0] REG_ALARM_MIN = 4'hb;
  localparam logic [3:0] REG_TIMER = 4'hc;
  localparam logic [3:0] REG_LAST = 4'hc;

  // ********************************
  // Fields and reset values.
  // ********************************
  localparam int CTRL1_TEST_BIT = 7;
  localparam int CTRL1_PFLAG_BIT = 1;
  localparam int CTRL2_AFLAG_BIT = 6;
  localparam int CTRL2_TFLAG_BIT = 3;
  localparam int OFFSET_MODE_BIT = 7;
  localparam int ALARM_EN_BIT = 7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_MON = 8'h01;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_LAST = 4'h7;

  typedef struct packed {
    logic alarm_ie;
    logic alarm_flag;
    logic min_ie;
    logic half_ie;
    logic timer_flag;
    logic timer_en;
    logic timer_ie;
    logic refclk_en;
  } ctrl2_t;

  typedef enum logic [7:0] {
    st_idle = 8'h01,
    st_addr = 8'h02,
    st_aack = 8'h04,
    st_ptr = 8'h08,
    st_wack = 8'h10,
    st_wdat = 8'h20,
    st_rdat = 8'h40,
    st_rack = 8'h80
  } bus_state_t;

endpackage : rtc_pkg

// File: logic/i2c_calendar_clock_core.sv
// Calendar clock core with a two-wire target port, tuning, alarm, timer and clock output.
`timescale 1ns/1ps
`default_nettype none
module i2c_calendar_clock_core #(
  parameter int SEC_CYCLES = rtc_pkg::SEC_CYCLES_DFLT,
  parameter logic [6:0] DEV_ADDR = rtc_pkg::DEV_ADDR_DFLT
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic refclk_en_pin,
  output logic reference_clock_output,
  output logic int_n
);

  // ********************************
  // Declarations.
  // ********************************
  rtc_pkg::bus_state_t state_ff;
  logic [7:0] regs_ff [0:rtc_pkg::REG_LAST];
  logic [7:0] sr_ff;
  logic [3:0] bitcnt_ff;
  logic [3:0] ptr_ff;
  logic [3:0] ptr_inc;
  logic rw_ff;
  logic mack_ff;
  logic scl_q_ff;
  logic sda_q_ff;
  logic start;
  logic stop;
  logic scl_rise;
  logic scl_fall;
  logic busy;
  logic bus_wr;
  logic [7:0] rd_data;
  logic pending_ff;
  logic tick_now;
  logic sec_tick;
  int pre_cnt_ff;
  int sec_len;
  logic [12:0] corr_cnt_ff;
  logic corr_now_ff;
  logic pflag_ff;
  logic aflag_ff;
  logic tflag_ff;
  logic int_n_ff;
  logic [7:0] tmr_cnt_ff;
  logic tmr_fire;
  logic [7:0] nxt_sec, nxt_min, nxt_hour, nxt_day, nxt_wday, nxt_mon, nxt_year;
  logic [7:0] dim;
  logic leap;
  logic c_sec, c_min, c_hour, c_day, c_mon;
  int clk_div_ff;
  logic ref_ff;
  rtc_pkg::ctrl2_t c2;

  assign c2 = regs_ff[rtc_pkg::REG_CTRL2];

  function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    if (v >= last) begin
      return first;
    end else if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_next

  // ********************************
  // Two-wire target port.
  // ********************************
  assign scl_rise = scl_i & ~scl_q_ff;
  assign scl_fall = ~scl_i & scl_q_ff;
  assign start = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign stop = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
  assign busy = (state_ff != rtc_pkg::st_idle);
  assign ptr_inc = (ptr_ff >= rtc_pkg::REG_LAST) ? 4'h0 : ptr_ff + 4'h1;
  assign bus_wr = scl_fall & (state_ff == rtc_pkg::st_wdat) & (bitcnt_ff == rtc_pkg::BITS_BYTE);
  assign sda_o = 1'b0;
  assign sda_oe = (state_ff == rtc_pkg::st_aack) | (state_ff == rtc_pkg::st_wack) |
                  ((state_ff == rtc_pkg::st_rdat) & ~sr_ff[7]);

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= rtc_pkg::st_idle;
      sr_ff <= 8'h00;
      bitcnt_ff <= 4'h0;
      ptr_ff <= 4'h0;
      rw_ff <= 1'b0;
      mack_ff <= 1'b1;
    end else if (start) begin
      state_ff <= rtc_pkg::st_addr;
      bitcnt_ff <= 4'h0;
    end else if (stop) begin
      state_ff <= rtc_pkg::st_idle;
    end else if (scl_rise) begin
      if (state_ff inside {rtc_pkg::st_addr, rtc_pkg::st_ptr, rtc_pkg::st_wdat}) begin
        sr_ff <= {sr_ff[6:0], sda_i};
        bitcnt_ff <= bitcnt_ff + 4'h1;
      end
      if (state_ff == rtc_pkg::st_rack) begin
        mack_ff <= sda_i;
      end
    end else if (scl_fall) begin
      case (state_ff)
        rtc_pkg::st_idle: begin
        end
        rtc_pkg::st_addr: begin
          if (bitcnt_ff == rtc_pkg::BITS_BYTE) begin
            if (sr_ff[7:1] == DEV_ADDR) begin
              state_ff <= rtc_pkg::st_aack;
              rw_ff <= sr_ff[0];
            end else begin
              state_ff <= rtc_pkg::st_idle;
            end
          end
        end
        rtc_pkg::st_aack: begin
          bitcnt_ff <= 4'h0;
          if (rw_ff) begin
            state_ff <= rtc_pkg::st_rdat;
            sr_ff <= rd_data;
            ptr_ff <= ptr_inc;
          end else begin
            state_ff <= rtc_pkg::st_ptr;
          end
        end
        rtc_pkg::st_ptr: begin
          if (bitcnt_ff == rtc_pkg::BITS_BYTE) begin
            ptr_ff <= sr_ff[3:0];
            state_ff <= rtc_pkg::st_wack;
          end
        end
        rtc_pkg::st_wdat: begin
          if (bitcnt_ff == rtc_pkg::BITS_BYTE) begin
            ptr_ff <= ptr_inc;
            state_ff <= rtc_pkg::st_wack;
          end
        end
        rtc_pkg::st_wack: begin
          state_ff <= rtc_pkg::st_wdat;
          bitcnt_ff <= 4'h0;
        end
        rtc_pkg::st_rdat: begin
          if (bitcnt_ff == rtc_pkg::BITS_LAST) begin
            state_ff <= rtc_pkg::st_rack;
          end else begin
            sr_ff <= {sr_ff[6:0], 1'b0};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end
        end
        rtc_pkg::st_rack: begin
          if (!mack_ff) begin
            state_ff <= rtc_pkg::st_rdat;
            sr_ff <= rd_data;
            ptr_ff <= ptr_inc;
            bitcnt_ff <= 4'h0;
          end else begin
            state_ff <= rtc_pkg::st_idle;
          end
        end
        default: begin
          state_ff <= rtc_pkg::st_idle;
        end
      endcase
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (ptr_ff <= rtc_pkg::REG_LAST) begin
      rd_data = regs_ff[ptr_ff];
    end
    if (ptr_ff == rtc_pkg::REG_CTRL1) begin
      rd_data[rtc_pkg::CTRL1_PFLAG_BIT] = pflag_ff;
    end
    if (ptr_ff == rtc_pkg::REG_CTRL2) begin
      rd_data[rtc_pkg::CTRL2_AFLAG_BIT] = aflag_ff;
      rd_data[rtc_pkg::CTRL2_TFLAG_BIT] = tflag_ff;
    end
  end

  // ********************************
  // Second prescaler and tuning.
  // ********************************
  always_comb begin
    sec_len = SEC_CYCLES;
    if (regs_ff[rtc_pkg::REG_CTRL1][rtc_pkg::CTRL1_TEST_BIT]) begin
      sec_len = SEC_CYCLES / rtc_pkg::TEST_SPEEDUP;
    end else if (corr_now_ff) begin
      sec_len = SEC_CYCLES - int'($signed(regs_ff[rtc_pkg::REG_OFFSET][6:0])) *
                rtc_pkg::PULSE_CYCLES;
    end
  end

  assign sec_tick = (pre_cnt_ff >= sec_len - 1);
  assign tick_now = (sec_tick | pending_ff) & ~busy;

  always_ff @(posedge clk) begin
    if (srst) begin
      pre_cnt_ff <= 0;
      corr_cnt_ff <= 13'h0000;
      corr_now_ff <= 1'b0;
    end else if (sec_tick) begin
      pre_cnt_ff <= 0;
      if (corr_cnt_ff >= (regs_ff[rtc_pkg::REG_OFFSET][rtc_pkg::OFFSET_MODE_BIT] ?
                          rtc_pkg::CORR1_SECONDS : rtc_pkg::CORR0_SECONDS) - 13'h0001) begin
        corr_cnt_ff <= 13'h0000;
        corr_now_ff <= 1'b1;
      end else begin
        corr_cnt_ff <= corr_cnt_ff + 13'h0001;
        corr_now_ff <= 1'b0;
      end
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pending_ff <= 1'b0;
    end else if (sec_tick & (busy | pending_ff)) begin
      pending_ff <= 1'b1;
    end else if (tick_now) begin
      pending_ff <= 1'b0;
    end
  end

  // ********************************
  // Calendar roll-over.
  // ********************************
  always_comb begin
    leap = regs_ff[rtc_pkg::REG_YEAR][4] ?
           (regs_ff[rtc_pkg::REG_YEAR][3:0] inside {4'h2, 4'h6}) :
           (regs_ff[rtc_pkg::REG_YEAR][3:0] inside {4'h0, 4'h4, 4'h8});
    case (regs_ff[rtc_pkg::REG_MON])
      8'h02: dim = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
    c_sec = regs_ff[rtc_pkg::REG_SEC] >= 8'h59;
    c_min = c_sec & (regs_ff[rtc_pkg::REG_MIN] >= 8'h59);
    c_hour = c_min & (regs_ff[rtc_pkg::REG_HOUR] >= 8'h23);
    c_day = c_hour & (regs_ff[rtc_pkg::REG_DAY] >= dim);
    c_mon = c_day & (regs_ff[rtc_pkg::REG_MON] >= 8'h12);
    nxt_sec = bcd_next(regs_ff[rtc_pkg::REG_SEC], 8'h59, 8'h00);
    nxt_min = c_sec ? bcd_next(regs_ff[rtc_pkg::REG_MIN], 8'h59, 8'h00) :
              regs_ff[rtc_pkg::REG_MIN];
    nxt_hour = c_min ? bcd_next(regs_ff[rtc_pkg::REG_HOUR], 8'h23, 8'h00) :
               regs_ff[rtc_pkg::REG_HOUR];
    nxt_day = c_hour ? bcd_next(regs_ff[rtc_pkg::REG_DAY], dim, 8'h01) :
              regs_ff[rtc_pkg::REG_DAY];
    nxt_wday = c_hour ? bcd_next(regs_ff[rtc_pkg::REG_WDAY], 8'h06, 8'h00) :
               regs_ff[rtc_pkg::REG_WDAY];
    nxt_mon = c_day ? bcd_next(regs_ff[rtc_pkg::REG_MON], 8'h12, 8'h01) :
              regs_ff[rtc_pkg::REG_MON];
    nxt_year = c_mon ? bcd_next(regs_ff[rtc_pkg::REG_YEAR], 8'h99, 8'h00) :
               regs_ff[rtc_pkg::REG_YEAR];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i <= int'(rtc_pkg::REG_LAST); i++) begin
        regs_ff[i] <= rtc_pkg::RST_ZERO;
      end
      regs_ff[rtc_pkg::REG_DAY] <= rtc_pkg::RST_DAY;
      regs_ff[rtc_pkg::REG_MON] <= rtc_pkg::RST_MON;
    end else begin
      if (tick_now) begin
        regs_ff[rtc_pkg::REG_SEC] <= nxt_sec;
        regs_ff[rtc_pkg::REG_MIN] <= nxt_min;
        regs_ff[rtc_pkg::REG_HOUR] <= nxt_hour;
        regs_ff[rtc_pkg::REG_DAY] <= nxt_day;
        regs_ff[rtc_pkg::REG_WDAY] <= nxt_wday;
        regs_ff[rtc_pkg::REG_MON] <= nxt_mon;
        regs_ff[rtc_pkg::REG_YEAR] <= nxt_year;
      end
      if (bus_wr && (ptr_ff <= rtc_pkg::REG_LAST)) begin
        regs_ff[ptr_ff] <= sr_ff;
      end
    end
  end

  // ********************************
  // Interrupt sources.
  // ********************************
  assign tmr_fire = tick_now & c2.timer_en & (tmr_cnt_ff <= 8'h01);

  always_ff @(posedge clk) begin
    if (srst) begin
      tmr_cnt_ff <= 8'h00;
    end else if (!c2.timer_en) begin
      tmr_cnt_ff <= regs_ff[rtc_pkg::REG_TIMER];
    end else if (tick_now) begin
      tmr_cnt_ff <= tmr_fire ? regs_ff[rtc_pkg::REG_TIMER] : tmr_cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pflag_ff <= 1'b0;
      aflag_ff <= 1'b0;
      tflag_ff <= 1'b0;
      int_n_ff <= 1'b1;
    end else begin
      pflag_ff <= (tick_now & ((c2.min_ie & (nxt_sec == 8'h00)) |
                   (c2.half_ie & ((nxt_sec == 8'h00) | (nxt_sec == 8'h30))))) |
                  (pflag_ff & ~(bus_wr & (ptr_ff == rtc_pkg::REG_CTRL1) &
                   ~sr_ff[rtc_pkg::CTRL1_PFLAG_BIT]));
      aflag_ff <= (tick_now & regs_ff[rtc_pkg::REG_ALARM_MIN][rtc_pkg::ALARM_EN_BIT] &
                   (nxt_sec == 8'h00) & (nxt_min[6:0] == regs_ff[rtc_pkg::REG_ALARM_MIN][6:0])) |
                  (aflag_ff & ~(bus_wr & (ptr_ff == rtc_pkg::REG_CTRL2) &
                   ~sr_ff[rtc_pkg::CTRL2_AFLAG_BIT]));
      tflag_ff <= tmr_fire | (tflag_ff & ~(bus_wr & (ptr_ff == rtc_pkg::REG_CTRL2) &
                  ~sr_ff[rtc_pkg::CTRL2_TFLAG_BIT]));
      int_n_ff <= ~(pflag_ff | (aflag_ff & c2.alarm_ie) | (tflag_ff & c2.timer_ie));
    end
  end

  assign int_n = int_n_ff;

  // ********************************
  // Reference clock output.
  // ********************************
  always_ff @(posedge clk) begin
    if (srst || !(refclk_en_pin || c2.refclk_en)) begin
      clk_div_ff <= 0;
      ref_ff <= 1'b0;
    end else if (clk_div_ff >= rtc_pkg::REFCLK_HALF_CYCLES - 1) begin
      clk_div_ff <= 0;
      ref_ff <= ~ref_ff;
    end else begin
      clk_div_ff <= clk_div_ff + 1;
    end
  end

  assign reference_clock_output = ref_ff;

  // ********************************
  // Assertions.
  // ********************************
  property p_freeze;
    @(posedge clk) disable iff (srst)
      (busy && $past(busy) && !$past(bus_wr)) |-> $stable(regs_ff[rtc_pkg::REG_SEC]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("time changed during access");
  property p_pend;
    @(posedge clk) disable iff (srst) (sec_tick && busy) |=> pending_ff;
  endproperty
  a_pend: assert property (p_pend) else $error("due second not held");
  property p_apply;
    @(posedge clk) disable iff (srst) ($fell(busy) && pending_ff) |-> tick_now;
  endproperty
  a_apply: assert property (p_apply) else $error("held second not applied");
  property p_secwrap;
    @(posedge clk) disable iff (srst)
      (tick_now && regs_ff[rtc_pkg::REG_SEC] == 8'h59 && regs_ff[rtc_pkg::REG_MIN] == 8'h59)
      |=> (regs_ff[rtc_pkg::REG_SEC] == 8'h00 && regs_ff[rtc_pkg::REG_MIN] == 8'h00);
  endproperty
  a_secwrap: assert property (p_secwrap) else $error("minute carry wrong");
  property p_leap;
    @(posedge clk) disable iff (srst)
      (tick_now && c_hour && regs_ff[rtc_pkg::REG_DAY] == 8'h28 &&
       regs_ff[rtc_pkg::REG_MON] == 8'h02 && regs_ff[rtc_pkg::REG_YEAR] == 8'h04)
      |=> regs_ff[rtc_pkg::REG_DAY] == 8'h29;
  endproperty
  a_leap: assert property (p_leap) else $error("leap day missed");
  property p_mlen;
    @(posedge clk) disable iff (srst)
      (tick_now && c_hour && regs_ff[rtc_pkg::REG_DAY] == 8'h30 &&
       regs_ff[rtc_pkg::REG_MON] == 8'h04)
      |=> (regs_ff[rtc_pkg::REG_DAY] == 8'h01 && regs_ff[rtc_pkg::REG_MON] == 8'h05);
  endproperty
  a_mlen: assert property (p_mlen) else $error("month length wrong");
  property p_period;
    @(posedge clk) disable iff (srst)
      (tick_now && c2.min_ie && nxt_sec == 8'h00) |=> ##1 !int_n;
  endproperty
  a_period: assert property (p_period) else $error("periodic interrupt missing");
  property p_scratch;
    @(posedge clk) disable iff (srst)
      (bus_wr && ptr_ff == rtc_pkg::REG_SCRATCH) |=> regs_ff[rtc_pkg::REG_SCRATCH] == $past(sr_ff);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch byte not stored");
  property p_ptr;
    @(posedge clk) disable iff (srst)
      (bus_wr && ptr_ff < rtc_pkg::REG_LAST) |=> ptr_ff == $past(ptr_ff) + 4'h1;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer did not advance");
  property p_refclk;
    @(posedge clk) disable iff (srst)
      !(refclk_en_pin || c2.refclk_en) |=> !reference_clock_output;
  endproperty
  a_refclk: assert property (p_refclk) else $error("clock output while disabled");

endmodule : i2c_calendar_clock_core
`default_nettype wire

// File: tb/i2c_host_model.sv
// Two-wire bus controller model that drives the register port of the clock core.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // ********************************
  // Bus phases, each held for one to four clocks.
  // ********************************
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  task automatic put_bit(input logic b);
    sda_pull = ~b;
    hold(3);
    scl = 1'b1;
    hold(4);
    scl = 1'b0;
    hold(1);
  endtask : put_bit
  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    hold(3);
    scl = 1'b1;
    hold(2);
    b = sda;
    hold(2);
    scl = 1'b0;
    hold(1);
  endtask : get_bit
  task automatic start;
    sda_pull = 1'b0;
    hold(3);
    scl = 1'b1;
    hold(4);
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b0;
    hold(1);
  endtask : start
  task automatic stop;
    sda_pull = 1'b1;
    hold(3);
    scl = 1'b1;
    hold(4);
    sda_pull = 1'b0;
    hold(4);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(last);
  endtask : rbyte
endmodule : i2c_host_model
`default_nettype wire

// File: tb/test_i2c_calendar_clock_core.sv
// Self-checking bench for the calendar clock core driven by the bus controller model.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_calendar_clock_core;
  // ********************************
  // Wiring, clock, counters and shared tasks.
  // ********************************
  localparam int SEC_CYC = 2000;
  localparam int LIMIT = 60000;
  localparam int PH = rtc_pkg::REFCLK_HALF_CYCLES;
  localparam logic [6:0] ADDR = rtc_pkg::DEV_ADDR_DFLT;
  logic clk;
  logic srst;
  logic refclk_en_pin;
  logic scl;
  logic sda_pull;
  logic sda_o;
  logic sda_oe;
  logic ref_clk;
  logic int_n;
  wire logic sda;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] wbuf [0:6];
  logic [7:0] rbuf [0:6];
  assign sda = ~sda_pull & (sda_oe ? sda_o : 1'b1);
  i2c_calendar_clock_core #(.SEC_CYCLES(SEC_CYC), .DEV_ADDR(ADDR)) i2c_calendar_clock_core_inst (
    .clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .refclk_en_pin(refclk_en_pin), .reference_clock_output(ref_clk), .int_n(int_n));
  i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test;
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic do_reset;
    srst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
  endtask : do_reset
  task automatic send(input logic [7:0] d);
    logic ack;
    host.wbyte(d, ack);
    chk1(ack, 1'b1);
  endtask : send
  task automatic wr(input logic [3:0] ptr, input int n);
    host.start();
    send({ADDR, 1'b0});
    send({4'h0, ptr});
    for (int i = 0; i < n; i++) begin
      send(wbuf[i]);
    end
    host.stop();
  endtask : wr
  task automatic rd(input logic [3:0] ptr, input int n, input int gap);
    host.start();
    send({ADDR, 1'b0});
    send({4'h0, ptr});
    host.hold(gap);
    host.start();
    send({ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      host.rbyte(rbuf[i], i == n - 1);
    end
    host.stop();
  endtask : rd
  task automatic wait_low(input int lim, output int t);
    t = 0;
    while (int_n !== 1'b0 && t < lim) begin
      @(posedge clk);
      #1;
      t++;
    end
  endtask : wait_low
  task automatic half(output int t);
    int n;
    n = 0;
    t = 0;
    while (ref_clk !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (ref_clk === 1'b1 && t < 4000) begin
      @(posedge clk);
      #1;
      t++;
    end
  endtask : half
  // ********************************
  // Scenarios.
  // ********************************
  task automatic reg_case;
    logic ack;
    do_reset();
    rd(rtc_pkg::REG_CTRL1, 4, 0);
    for (int i = 0; i < 4; i++) begin
      chk8(rbuf[i], rtc_pkg::RST_ZERO);
    end
    wbuf[0] = 8'h81;
    wbuf[1] = 8'h5a;
    wr(rtc_pkg::REG_OFFSET, 2);
    rd(rtc_pkg::REG_OFFSET, 2, 0);
    chk8(rbuf[0], 8'h81);
    chk8(rbuf[1], 8'h5a);
    rd(4'he, 1, 0);
    chk8(rbuf[0], 8'h00);
    host.start();
    host.wbyte({ADDR ^ 7'h01, 1'b0}, ack);
    host.stop();
    chk1(ack, 1'b0);
  endtask : reg_case
  task automatic cal_case(input logic [7:0] d, m, y, ed, em, ey);
    logic [7:0] e [0:6];
    e = '{8'h00, 8'h00, 8'h00, ed, 8'h00, em, ey};
    do_reset();
    wbuf = '{8'h59, 8'h59, 8'h23, d, 8'h06, m, y};
    wr(rtc_pkg::REG_SEC, 7);
    host.hold(1600);
    rd(rtc_pkg::REG_SEC, 7, 0);
    for (int i = 0; i < 7; i++) begin
      chk8(rbuf[i], e[i]);
    end
  endtask : cal_case
  task automatic freeze_case;
    do_reset();
    host.hold(1000);
    rd(rtc_pkg::REG_SEC, 2, 1150);
    chk8(rbuf[0], 8'h00);
    chk8(rbuf[1], 8'h00);
    rd(rtc_pkg::REG_SEC, 1, 0);
    chk8(rbuf[0], 8'h01);
  endtask : freeze_case
  task automatic int_case;
    int t;
    do_reset();
    wbuf[0] = 8'h80;
    wbuf[1] = 8'h10;
    wr(rtc_pkg::REG_CTRL1, 2);
    wait_low(1200, t);
    chk_rng(t, 600, 1000);
    wbuf[1] = 8'h20;
    wr(rtc_pkg::REG_CTRL1, 2);
    chk1(int_n, 1'b1);
    wait_low(1500, t);
    chk_rng(t, 600, 1000);
    wr(rtc_pkg::REG_CTRL1, 1);
    wait_low(1100, t);
    chk_rng(t, 1100, 1100);
    wbuf = '{8'h04, 8'h80, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
    wr(rtc_pkg::REG_TIMER, 3);
    wait_low(300, t);
    chk_rng(t, 60, 200);
    wbuf = '{8'h85, 8'h04, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
    wr(rtc_pkg::REG_ALARM_MIN, 4);
    chk1(int_n, 1'b1);
    wbuf[0] = 8'h58;
    wbuf[1] = 8'h04;
    wr(rtc_pkg::REG_SEC, 2);
    wait_low(100, t);
    chk_rng(t, 0, 40);
  endtask : int_case
  task automatic clk_case;
    int t;
    do_reset();
    refclk_en_pin = 1'b1;
    half(t);
    half(t);
    chk_rng(t, PH - 1, PH + 1);
    refclk_en_pin = 1'b0;
    host.hold(2);
    half(t);
    chk_rng(t, 0, 0);
    wbuf[0] = 8'h01;
    wr(rtc_pkg::REG_CTRL2, 1);
    half(t);
    half(t);
    chk_rng(t, PH - 1, PH + 1);
  endtask : clk_case
  initial begin
    srst = 1'b1;
    refclk_en_pin = 1'b0;
    reg_case();
    cal_case(8'h31, 8'h12, 8'h03, 8'h01, 8'h01, 8'h04);
    cal_case(8'h28, 8'h02, 8'h04, 8'h29, 8'h02, 8'h04);
    cal_case(8'h28, 8'h02, 8'h05, 8'h01, 8'h03, 8'h05);
    cal_case(8'h30, 8'h04, 8'h05, 8'h01, 8'h05, 8'h05);
    cal_case(8'h09, 8'h01, 8'h05, 8'h10, 8'h01, 8'h05);
    freeze_case();
    int_case();
    clk_case();
    stop_test();
  end
endmodule : test_i2c_calendar_clock_core
`default_nettype wire
